/* File: rtl/nvsr_regs.svh */
// Constants for the nonvolatile store/recall host controller
`ifndef NVSR_REGS_SVH
`define NVSR_REGS_SVH

`define NVSR_SEQ_A1        13'h0000
`define NVSR_SEQ_A2        13'h1555
`define NVSR_SEQ_A3        13'h0aaa
`define NVSR_SEQ_A4        13'h1fff
`define NVSR_SEQ_A5        13'h10f0
`define NVSR_SEQ_RECALL    13'h0f0e
`define NVSR_SEQ_STORE     13'h0f0f
`define NVSR_CLK_NS        100
`define NVSR_ASSERT_NS     250
`define NVSR_ASSERT_CYC    ((`NVSR_ASSERT_NS + `NVSR_CLK_NS - 1) / `NVSR_CLK_NS)
`define NVSR_CYC_W         4
`define NVSR_ACC_CYC       4'h2
`define NVSR_BUSY_TMO      32'd200000

`endif

/* File: rtl/nvsr_pkg.sv */
// Types for the nonvolatile store/recall host controller
package nvsr_pkg;

   typedef enum logic [6:0] {
      NVSR_IDLE   = 7'h01,
      NVSR_ACC    = 7'h02,
      NVSR_GAP    = 7'h04,
      NVSR_HPULL  = 7'h08,
      NVSR_HWAIT  = 7'h10,
      NVSR_HREL   = 7'h20,
      NVSR_DONE   = 7'h40
   } nvsr_state_e;

   typedef struct packed {
      logic        start;
      logic        write;
      logic [12:0] addr;
      logic [7:0]  wdata;
   } nvsr_req_s;

   typedef struct packed {
      logic        ce_n;
      logic        we_n;
      logic        oe_n;
      logic [12:0] addr;
      logic [7:0]  dq_out;
      logic        dq_oe_n;
   } nvsr_bus_s;

endpackage : nvsr_pkg

/* File: rtl/nvsr_host.sv */
// Host controller driving the nonvolatile memory bus and the store/busy line
// Behaviour
// - Recall is six reads: 0000,1555,0AAA,1FFF,10F0,0F0E.
// - Host keeps write strobe inactive during the power-up recall.
// - Line held low beyond minimum assert time starts a store.
// - Outside logic may hold line high to suppress automatic stores.
// - Software store is same five reads then read 0F0F.
// - Any other access interrupting the sequence aborts it.
// - Outside logic holds store/busy low at least 250 ns.
`timescale 1ns/10ps
`include "nvsr_regs.svh"

module nvsr_host
(
   input  wire logic               ref_clk,
   input  wire logic               reset_n,
   input  wire nvsr_pkg::nvsr_req_s req,
   input  wire logic               sw_store,
   input  wire logic               sw_recall,
   input  wire logic               hw_store,
   input  wire logic [7:0]         dq_in,
   input  wire logic               store_busy_n_in,
   output logic                    busy,
   output logic                    done,
   output logic                    timeout,
   output logic [7:0]              rdata,
   output nvsr_pkg::nvsr_bus_s     bus,
   output logic                    store_busy_n_out,
   output logic                    store_busy_n_oe_n
);

   ////////////////////////////////////////////////////////////////////////////
   // State
   nvsr_pkg::nvsr_state_e state_q, state_d;
   logic [`NVSR_CYC_W-1:0] cnt_q, cnt_d;
   logic [2:0]             seq_q, seq_d;
   logic                   seq_on_q, seq_on_d;
   logic                   last_q, last_d;
   logic [12:0]            addr_q, addr_d;
   logic [7:0]             wdat_q, wdat_d;
   logic                   wr_q, wr_d;
   logic [31:0]            tmo_q, tmo_d;
   logic                   busy_q, busy_d;
   logic                   done_q, done_d;
   logic                   tmo_f_q, tmo_f_d;
   logic [7:0]             rdata_q, rdata_d;
   nvsr_pkg::nvsr_bus_s    bus_q, bus_d;
   logic                   hoe_n_q, hoe_n_d;

   // Address of each step of the six-read sequence
   function automatic logic [12:0] seq_addr(input logic [2:0] i, input logic rec);
      case (i)
         3'h0:    seq_addr = `NVSR_SEQ_A1;
         3'h1:    seq_addr = `NVSR_SEQ_A2;
         3'h2:    seq_addr = `NVSR_SEQ_A3;
         3'h3:    seq_addr = `NVSR_SEQ_A4;
         3'h4:    seq_addr = `NVSR_SEQ_A5;
         default: seq_addr = rec ? `NVSR_SEQ_RECALL : `NVSR_SEQ_STORE;
      endcase
   endfunction : seq_addr

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb
   begin
      state_d  = state_q;
      cnt_d    = cnt_q;
      seq_d    = seq_q;
      seq_on_d = seq_on_q;
      last_d   = last_q;
      addr_d   = addr_q;
      wdat_d   = wdat_q;
      wr_d     = wr_q;
      tmo_d    = tmo_q;
      busy_d   = busy_q;
      done_d   = 1'b0;
      tmo_f_d  = 1'b0;
      rdata_d  = rdata_q;
      bus_d    = bus_q;
      hoe_n_d  = 1'b1;
      case (state_q)
         nvsr_pkg::NVSR_IDLE:
         begin
            bus_d.ce_n    = 1'b1;
            bus_d.we_n    = 1'b1;
            bus_d.oe_n    = 1'b1;
            bus_d.dq_oe_n = 1'b1;
            busy_d        = 1'b0;
            if (hw_store)
            begin
               hoe_n_d = 1'b0;
               cnt_d   = '0;
               busy_d  = 1'b1;
               state_d = nvsr_pkg::NVSR_HPULL;
            end
            else if (sw_store || sw_recall)
            begin
               // Sequence reads go back to back, no foreign access between
               seq_d    = 3'h0;
               seq_on_d = 1'b1;
               last_d   = sw_recall;
               addr_d   = seq_addr(3'h0, sw_recall);
               wr_d     = 1'b0;
               busy_d   = 1'b1;
               cnt_d    = '0;
               state_d  = nvsr_pkg::NVSR_ACC;
            end
            else if (req.start && store_busy_n_in)
            begin
               seq_on_d = 1'b0;
               addr_d   = req.addr;
               wdat_d   = req.wdata;
               wr_d     = req.write;
               busy_d   = 1'b1;
               cnt_d    = '0;
               state_d  = nvsr_pkg::NVSR_ACC;
            end
         end
         nvsr_pkg::NVSR_ACC:
         begin
            bus_d.addr    = addr_q;
            bus_d.dq_out  = wdat_q;
            bus_d.ce_n    = 1'b0;
            bus_d.we_n    = ~wr_q;
            bus_d.oe_n    = wr_q;
            bus_d.dq_oe_n = ~wr_q;
            cnt_d         = cnt_q + 1'b1;
            if (cnt_q == `NVSR_ACC_CYC)
            begin
               if (!wr_q)
               begin
                  rdata_d = dq_in;
               end
               bus_d.ce_n = 1'b1;
               bus_d.we_n = 1'b1;
               bus_d.oe_n = 1'b1;
               state_d    = nvsr_pkg::NVSR_GAP;
            end
         end
         nvsr_pkg::NVSR_GAP:
         begin
            bus_d.dq_oe_n = 1'b1;
            cnt_d         = '0;
            if (seq_on_q && seq_q != 3'h5)
            begin
               seq_d   = seq_q + 3'h1;
               addr_d  = seq_addr(seq_q + 3'h1, last_q);
               state_d = nvsr_pkg::NVSR_ACC;
            end
            else if (seq_on_q)
            begin
               // Device now runs its cycle ignoring inputs; wait for idle line
               tmo_d   = '0;
               state_d = nvsr_pkg::NVSR_HREL;
            end
            else
            begin
               state_d = nvsr_pkg::NVSR_DONE;
            end
         end
         nvsr_pkg::NVSR_HPULL:
         begin
            hoe_n_d = 1'b0;
            cnt_d   = cnt_q + 1'b1;
            if (cnt_q == `NVSR_CYC_W'(`NVSR_ASSERT_CYC))
            begin
               hoe_n_d = 1'b1;
               tmo_d   = '0;
               state_d = nvsr_pkg::NVSR_HREL;
            end
         end
         nvsr_pkg::NVSR_HREL:
         begin
            // Wait until no device holds the shared line low
            tmo_d = tmo_q + 32'd1;
            if (store_busy_n_in)
            begin
               state_d = nvsr_pkg::NVSR_DONE;
            end
            else if (tmo_q == `NVSR_BUSY_TMO)
            begin
               tmo_f_d = 1'b1;
               state_d = nvsr_pkg::NVSR_DONE;
            end
         end
         nvsr_pkg::NVSR_DONE:
         begin
            done_d  = 1'b1;
            busy_d  = 1'b0;
            state_d = nvsr_pkg::NVSR_IDLE;
         end
         default:
         begin
            state_d = nvsr_pkg::NVSR_IDLE;
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge ref_clk)
   begin
      if (!reset_n)
      begin
         state_q  <= nvsr_pkg::NVSR_IDLE;
         cnt_q    <= '0;
         seq_q    <= '0;
         seq_on_q <= 1'b0;
         last_q   <= 1'b0;
         addr_q   <= '0;
         wdat_q   <= '0;
         wr_q     <= 1'b0;
         tmo_q    <= '0;
         busy_q   <= 1'b0;
         done_q   <= 1'b0;
         tmo_f_q  <= 1'b0;
         rdata_q  <= '0;
         bus_q    <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: 13'h0000,
                       dq_out: 8'h00, dq_oe_n: 1'b1};
         hoe_n_q  <= 1'b1;
      end
      else
      begin
         state_q  <= state_d;
         cnt_q    <= cnt_d;
         seq_q    <= seq_d;
         seq_on_q <= seq_on_d;
         last_q   <= last_d;
         addr_q   <= addr_d;
         wdat_q   <= wdat_d;
         wr_q     <= wr_d;
         tmo_q    <= tmo_d;
         busy_q   <= busy_d;
         done_q   <= done_d;
         tmo_f_q  <= tmo_f_d;
         rdata_q  <= rdata_d;
         bus_q    <= bus_d;
         hoe_n_q  <= hoe_n_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign busy              = busy_q;
   assign done              = done_q;
   assign timeout           = tmo_f_q;
   assign rdata             = rdata_q;
   assign bus               = bus_q;
   // Open drain only: never driven high, so automatic stores are never overpowered
   assign store_busy_n_out  = 1'b0;
   assign store_busy_n_oe_n = hoe_n_q;

endmodule : nvsr_host

/* File: test/nvsr_host_properties.sv */
// Port checks for the store/recall host controller
`timescale 1ns/10ps
`include "nvsr_regs.svh"
module nvsr_host_properties
(
   input  wire logic                ref_clk,
   input  wire logic                reset_n,
   input  wire nvsr_pkg::nvsr_req_s req,
   input  wire logic                sw_store,
   input  wire logic                sw_recall,
   input  wire logic                hw_store,
   input  wire logic                store_busy_n_in,
   input  wire logic                busy,
   input  wire nvsr_pkg::nvsr_bus_s bus,
   input  wire logic                store_busy_n_oe_n
);
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   ////////////////////////////////////////
   // Five common reads, one access every 4 cycles
   sequence seq_head;
      bus.addr == `NVSR_SEQ_A1 ##4 bus.addr == `NVSR_SEQ_A2 ##4 bus.addr == `NVSR_SEQ_A3
      ##4 bus.addr == `NVSR_SEQ_A4 ##4 bus.addr == `NVSR_SEQ_A5;
   endsequence
   recall_seq_a: assert property ($rose(busy) && $past(sw_recall && !hw_store)
      |-> ##1 seq_head ##4 bus.addr == `NVSR_SEQ_RECALL) else $error("bad recall sequence");
   store_seq_a: assert property ($rose(busy) && $past(sw_store && !sw_recall && !hw_store)
      |-> ##1 seq_head ##4 bus.addr == `NVSR_SEQ_STORE) else $error("bad store sequence");
   seq_reads_a: assert property ($rose(busy) && $past(sw_store || sw_recall)
      |-> bus.we_n[*8]) else $error("write inside sequence");
   access_whole_a: assert property ($fell(bus.ce_n)
      |-> !bus.ce_n[*2] ##1 bus.ce_n) else $error("access length wrong");
   pin_pull_a: assert property ($rose(busy) && $past(hw_store)
      |-> !store_busy_n_oe_n) else $error("pin store not pulled");
   pin_hold_a: assert property ($fell(store_busy_n_oe_n)
      |-> !store_busy_n_oe_n[*3]) else $error("store pulse too short");
   line_gate_a: assert property ($rose(busy) && $past(req.start && !hw_store && !sw_store && !sw_recall)
      |-> $past(store_busy_n_in)) else $error("access while line low");
   pwrup_we_a: assert property ($rose(reset_n) |-> bus.we_n)
      else $error("write strobe at power-up");
   cover property ($rose(busy) && $past(sw_store));
   cover property ($rose(busy) && $past(sw_recall));
   cover property ($fell(store_busy_n_oe_n));
endmodule : nvsr_host_properties

bind nvsr_host nvsr_host_properties u_nvsr_host_properties (.ref_clk, .reset_n, .req,
   .sw_store, .sw_recall, .hw_store, .store_busy_n_in, .busy, .bus, .store_busy_n_oe_n);

/* File: test/nvsr_dev_model.sv */
// Behavioural model of the nonvolatile memory device
`timescale 1ns/10ps
`include "nvsr_regs.svh"
module nvsr_dev_model #(parameter int STORE_CYC = 20)
(
   input  wire logic                ref_clk,
   input  wire nvsr_pkg::nvsr_bus_s bus,
   input  wire logic                line_n,
   input  wire logic                cap_ok,
   output logic [7:0]               dq,
   output logic                     pull_n = 1'b1
);
   logic [7:0]  mem [8192];
   logic [7:0]  shadow [8192];
   logic [7:0]  last_q = 8'h00;
   logic [12:0] tab [5] = '{`NVSR_SEQ_A1, `NVSR_SEQ_A2, `NVSR_SEQ_A3, `NVSR_SEQ_A4, `NVSR_SEQ_A5};
   nvsr_pkg::nvsr_bus_s pb;
   int          seq_q = 0, cnt_q = 0, low_q = 0;
   logic        dirty_q = 1'b0;
   logic        cap_q = 1'b1;
   ////////////////////////////////////////
   // Read data, otherwise a changing pattern
   assign dq = (!bus.ce_n && !bus.oe_n && bus.we_n) ? mem[bus.addr] : ~last_q;
   // Copy to shadow and pull the line
   task automatic start_store;
      shadow = mem;
      dirty_q = 1'b0;
      cnt_q <= STORE_CYC;
      pull_n <= 1'b0;
   endtask : start_store
   // Store timing, pin requests and access decoding
   always @(posedge ref_clk)
   begin
      pb <= bus;
      last_q <= dq;
      cap_q <= cap_ok;
      if (cnt_q != 0)
      begin
         cnt_q <= cnt_q - 1;
         pull_n <= (cnt_q == 1);
         low_q <= 0;
      end
      else
      begin
         low_q <= line_n ? 0 : low_q + 1;
         if (low_q == `NVSR_ASSERT_CYC - 1 && cap_ok && dirty_q)
            start_store;
         // Supply loss saves, supply return reloads; host never holds the line up
         if (cap_q && !cap_ok && dirty_q)
            start_store;
         if (!cap_q && cap_ok)
            mem = shadow;
         if (!pb.ce_n && bus.ce_n && !pb.we_n)
         begin
            // A write ending while the line is low is dropped
            if (line_n)
            begin
               mem[pb.addr] = pb.dq_out;
               dirty_q = 1'b1;
            end
            seq_q = 0;
         end
         else if (!pb.ce_n && bus.ce_n && seq_q == 5 && pb.addr == `NVSR_SEQ_RECALL)
         begin
            mem = shadow;
            seq_q = 0;
         end
         else if (!pb.ce_n && bus.ce_n && seq_q == 5 && pb.addr == `NVSR_SEQ_STORE)
         begin
            start_store;
            seq_q = 0;
         end
         else if (!pb.ce_n && bus.ce_n)
            seq_q = (seq_q < 5 && pb.addr == tab[seq_q]) ? seq_q + 1 : int'(pb.addr == 0);
      end
   end
endmodule : nvsr_dev_model

/* File: test/nvsr_host_test.sv */
// Testbench for the store/recall host controller
`timescale 1ns/10ps
module nvsr_host_test;
   logic                ref_clk = 0;
   logic                reset_n = 0;
   nvsr_pkg::nvsr_req_s req = '0;
   logic [2:0]          kick_q = 3'h0;
   logic [7:0]          dq_in, rdata;
   logic                busy, done, timeout, sb_out, sb_oe_n, dev_pull_n;
   logic                ext_n = 1;
   logic                cap_ok = 1;
   nvsr_pkg::nvsr_bus_s bus;
   wire logic           line_n = sb_oe_n & dev_pull_n & ext_n;
   int                  fails = 0, n_tests = 0, cyc = 0;
   ////////////////////////////////////////
   // Clock, host under test and device model
   initial forever #50 ref_clk = ~ref_clk;
   nvsr_host u_nvsr_host (.ref_clk, .reset_n, .req, .sw_store(kick_q[1]),
      .sw_recall(kick_q[0]), .hw_store(kick_q[2]), .dq_in, .store_busy_n_in(line_n), .busy,
      .done, .timeout, .rdata, .bus, .store_busy_n_out(sb_out), .store_busy_n_oe_n(sb_oe_n));
   nvsr_dev_model u_nvsr_dev_model (.ref_clk, .bus, .line_n, .cap_ok, .dq(dq_in),
      .pull_n(dev_pull_n));
   ////////////////////////////////////////
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_tests, fails);
      if (fails == 0 && n_tests > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask : end_of_test
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      n_tests++;
      if (seen !== exp)
      begin
         fails++;
         $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   // Wait for done, check timeout in the done cycle (its one-cycle pulse comes the cycle before), step into idle
   task automatic wait_done;
      for (int i = 0; i < 100 && done !== 1'b1; i++)
         @(posedge ref_clk) #10;
      chk({7'h0, done}, 8'h01);
      chk({7'h0, timeout}, 8'h00);
      @(posedge ref_clk) #10;
   endtask : wait_done
   task automatic op(input logic wr, input logic [12:0] a, input logic [7:0] d);
      req = '{1'b1, wr, a, d};
      @(posedge ref_clk) #10;
      req.start = 1'b0;
      wait_done;
   endtask : op
   task automatic kick(input logic [2:0] k);
      kick_q = k;
      @(posedge ref_clk) #10;
      kick_q = 3'h0;
      wait_done;
   endtask : kick
   ////////////////////////////////////////
   task automatic t_sw;
      op(1'b1, 13'h1fff, 8'h3c);
      op(1'b1, 13'h0200, 8'h11);
      kick(3'h2);
      op(1'b1, 13'h0200, 8'h22);
      op(1'b0, 13'h0200, 8'h00);
      chk(rdata, 8'h22);
      kick(3'h1);
      op(1'b0, 13'h0200, 8'h00);
      chk(rdata, 8'h11);
      kick(3'h3);
      op(1'b0, 13'h1fff, 8'h00);
      chk(rdata, 8'h3c);
   endtask : t_sw
   task automatic t_pin;
      op(1'b1, 13'h0300, 8'h77);
      kick(3'h4);
      chk({7'h0, sb_out}, 8'h00);
      op(1'b1, 13'h0300, 8'h99);
      kick(3'h1);
      op(1'b0, 13'h0300, 8'h00);
      chk(rdata, 8'h77);
   endtask : t_pin
   task automatic t_gate;
      ext_n = 1'b0;
      req = '{1'b1, 1'b0, 13'h0200, 8'h00};
      repeat (8) @(posedge ref_clk) #10;
      chk({7'h0, busy}, 8'h00);
      ext_n = 1'b1;
      wait (line_n === 1'b1);
      @(posedge ref_clk) #10;
      req.start = 1'b0;
      wait_done;
      chk(rdata, 8'h11);
   endtask : t_gate
   // Supply dip saves, pin request ignored while low, return reloads
   task automatic t_power;
      op(1'b1, 13'h0400, 8'h5a);
      cap_ok = 1'b0;
      repeat (2) @(posedge ref_clk) #10;
      wait (line_n === 1'b1);
      @(posedge ref_clk) #10;
      op(1'b1, 13'h0400, 8'ha5);
      kick(3'h4);
      cap_ok = 1'b1;
      repeat (2) @(posedge ref_clk) #10;
      op(1'b0, 13'h0400, 8'h00);
      chk(rdata, 8'h5a);
   endtask : t_power
   // Cut a hang short
   always @(posedge ref_clk)
   begin
      cyc++;
      if (cyc == 3000)
      begin
         fails++;
         end_of_test;
      end
   end
   // Reset, then the scenarios
   initial
   begin
      repeat (6) @(posedge ref_clk);
      #10 reset_n = 1'b1;
      t_sw;
      t_pin;
      t_gate;
      t_power;
      end_of_test;
   end
endmodule : nvsr_host_test
